/* logic/irsp_pkg.sv */
// Shared constants for the two-wire register slave port and its master end
package irsp_pkg;
  localparam int          CLK_HZ          = 20000000;           // System clock rate
  localparam int          CLK_PERIOD_NS   = 50;                 // System clock period
  localparam int          SPIKE_NS        = 50;                 // Spike suppression limit
  // Longest time rounds down, at least one cycle
  localparam int          SPIKE_CYC       = (SPIKE_NS / CLK_PERIOD_NS) < 1 ? 1 : (SPIKE_NS / CLK_PERIOD_NS);
  localparam int          STD_RATE_HZ     = 100000;             // Standard-mode bus rate
  localparam int          FAST_RATE_HZ    = 400000;             // Fast-mode bus rate
  localparam int          SCL_HALF_CYC    = CLK_HZ / FAST_RATE_HZ / 2; // Master half period at fast rate
  localparam logic [3:0]  ADDR_FIXED      = 4'h9;               // Upper slave address bits 1001
  localparam int          ADDR_W          = 16;                 // Register address width
  localparam int          BYTE_W          = 8;                  // Bits per byte
  localparam logic [15:0] REG_PTR_RST     = 16'h0000;           // Register pointer after reset
  localparam int          FIFO_DEPTH      = 16;                 // Read-data buffer depth
  localparam logic        DIR_WRITE       = 1'b0;               // Direction bit for write
  localparam logic        DIR_READ        = 1'b1;               // Direction bit for read
endpackage

/* logic/irsp_if.sv */
// Two-wire link between the register slave port and its master
`timescale 1ns/1ps
interface irsp_if;
  logic scl_o;   // Master clock drive (low when enabled)
  logic scl_oe;
  logic sda_m_o; // Master data drive
  logic sda_m_oe;
  logic sda_s_o; // Slave data drive
  logic sda_s_oe;
  wire  scl = scl_oe ? scl_o : 1'b1;
  wire  sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);
  modport slave (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport master (input scl, input sda, output scl_o, output scl_oe, output sda_m_o, output sda_m_oe);
endinterface

/* logic/irsp_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module irsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             CLK,
  input  wire logic             ARST_N,
  input  wire logic [WIDTH-1:0] IN_DATA,
  input  wire logic             IN_VALID,
  output logic                  IN_READY,
  output logic      [WIDTH-1:0] OUT_DATA,
  output logic                  OUT_VALID,
  input  wire logic             OUT_READY
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [AW:0]      cnt_ff, nxt_cnt;
  logic             push, pop;

  // Pointer and count update; full and empty come straight from the count
  always_comb begin
    IN_READY  = (cnt_ff != (AW+1)'(DEPTH));
    OUT_VALID = (cnt_ff != '0);
    OUT_DATA  = mem_ff[rp_ff];
    push      = IN_VALID && IN_READY;
    pop       = OUT_VALID && OUT_READY;
    nxt_wp    = push ? wp_ff + 1'b1 : wp_ff;
    nxt_rp    = pop ? rp_ff + 1'b1 : rp_ff;
    nxt_cnt   = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage has no reset; only written entries are ever read
  always_ff @(posedge CLK) begin
    if (push) begin
      mem_ff[wp_ff] <= IN_DATA;
    end
  end
endmodule

/* logic/irsp_slave.sv */
// Device end: two-wire slave giving a master access to a 16-bit register space
`timescale 1ns/1ps
// Functional notes
// R1 - Works at 100 kHz and 400 kHz
// R2 - Ignore clock/data pulses under 50 ns
// R3 - Slave only, never drives clock
// R4 - Register address is 16 bits, two bytes
// R5 - Address 1001 plus three strap pins
// R6 - Respond only to matching slave address
// R7 - Data changes only while clock low
// R8 - Detect start and stop conditions
// R9 - Eight bits MSB first plus ack
// R10 - Ack by holding data low ninth pulse
// R11 - Nack leaves data high ninth pulse
// R12 - Address byte: seven bits then direction
// R13 - Ack matched address, then follow direction
// R14 - No limit on transfer length
// R15 - Two address bytes high first, then data
// R16 - Read returns data from held pointer
// R17 - Nack on read ends; release and idle
// R18 - Master stops after last write ack
// R19 - Restart ends transfer; partial byte dropped
// R20 - Address-only write loads pointer only
// R21 - Combined read: address write, restart, read
// R22 - Pointer advances after each data byte
// R23 - Denied or missing registers read zero
module irsp_slave
  import irsp_pkg::*;
#(
  parameter int FILT_CYC = irsp_pkg::SPIKE_CYC + 1
) (
  input  wire logic                      CLK,
  input  wire logic                      ARST_N,
  irsp_if.slave                          LINK,
  input  wire logic [2:0]                STRAP,
  output logic      [irsp_pkg::ADDR_W-1:0] REG_ADDR,
  output logic                           REG_WR,
  output logic      [irsp_pkg::BYTE_W-1:0] REG_WDATA,
  output logic                           REG_RD,
  input  wire logic [irsp_pkg::BYTE_W-1:0] REG_RDATA,
  input  wire logic                      REG_OK
);
  import irsp_pkg::*;

  typedef enum {ST_IDLE, ST_ADDR, ST_RXB, ST_TXB, ST_ACK_RX, ST_ACK_TX} irsp_st_t;
  typedef enum {PH_AHI, PH_ALO, PH_DATA} irsp_ph_t;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and glitch filter
  logic [1:0] scl_s_ff, sda_s_ff, nxt_scl_s, nxt_sda_s;
  logic       scl_f_ff, sda_f_ff, nxt_scl_f, nxt_sda_f;
  logic [3:0] scl_c_ff, sda_c_ff, nxt_scl_c, nxt_sda_c;
  logic       scl_d_ff, sda_d_ff;
  logic       strap_done_ff;
  logic [2:0] strap_ff;

  // Filter needs a level to hold FILT_CYC clocks, longer than the spike limit
  always_comb begin
    nxt_scl_s = {scl_s_ff[0], LINK.scl};
    nxt_sda_s = {sda_s_ff[0], LINK.sda};
    nxt_scl_f = scl_f_ff;
    nxt_sda_f = sda_f_ff;
    nxt_scl_c = '0;
    nxt_sda_c = '0;
    if (scl_s_ff[1] != scl_f_ff) begin
      nxt_scl_c = scl_c_ff + 4'h1;
      if (scl_c_ff >= 4'(FILT_CYC - 1)) begin
        nxt_scl_f = scl_s_ff[1]; // see R2
        nxt_scl_c = '0;
      end
    end
    if (sda_s_ff[1] != sda_f_ff) begin
      nxt_sda_c = sda_c_ff + 4'h1;
      if (sda_c_ff >= 4'(FILT_CYC - 1)) begin
        nxt_sda_f = sda_s_ff[1]; // see R2
        nxt_sda_c = '0;
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scl_s_ff <= 2'h3;
      sda_s_ff <= 2'h3;
      scl_f_ff <= 1'b1;
      sda_f_ff <= 1'b1;
      scl_c_ff <= 4'h0;
      sda_c_ff <= 4'h0;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_s_ff <= nxt_scl_s;
      sda_s_ff <= nxt_sda_s;
      scl_f_ff <= nxt_scl_f;
      sda_f_ff <= nxt_sda_f;
      scl_c_ff <= nxt_scl_c;
      sda_c_ff <= nxt_sda_c;
      scl_d_ff <= scl_f_ff;
      sda_d_ff <= sda_f_ff;
    end
  end

  // Straps are caught once, on the first clock after reset release
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      strap_done_ff <= 1'b0;
      strap_ff      <= 3'h0;
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'b1;
      strap_ff      <= STRAP; // see R5
    end
  end

  wire scl_rise = scl_f_ff && !scl_d_ff; // Sample point, a few clocks behind the pin, see R1
  wire scl_fall = !scl_f_ff && scl_d_ff; // Drive point
  wire start_c  = scl_f_ff && scl_d_ff && sda_d_ff && !sda_f_ff; // see R8
  wire stop_c   = scl_f_ff && scl_d_ff && !sda_d_ff && sda_f_ff; // see R8

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine
  irsp_st_t         st_ff, nxt_st;
  irsp_ph_t         ph_ff, nxt_ph;
  logic [7:0]       sh_ff, nxt_sh;
  logic [3:0]       bit_ff, nxt_bit;
  logic [15:0]      ptr_ff, nxt_ptr; // see R4
  logic             rw_ff, nxt_rw;
  logic             sda_oe_ff, nxt_sda_oe;
  logic             wr_ff, nxt_wr;
  logic [7:0]       wd_ff, nxt_wd;
  logic             rd_ff, nxt_rd;
  logic             nack_ff, nxt_nack;
  logic [6:0]       my_addr;

  assign my_addr = {ADDR_FIXED, strap_ff}; // see R5

  always_comb begin
    nxt_st     = st_ff;
    nxt_ph     = ph_ff;
    nxt_sh     = sh_ff;
    nxt_bit    = bit_ff;
    nxt_ptr    = ptr_ff;
    nxt_rw     = rw_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_wr     = 1'b0;
    nxt_wd     = wd_ff;
    nxt_rd     = 1'b0;
    nxt_nack   = nack_ff;
    if (start_c) begin
      // Restart behaves like stop plus start; partial byte is lost
      nxt_st     = ST_ADDR; // see R19
      nxt_bit    = 4'h0; // see R21
      nxt_sda_oe = 1'b0;
    end else if (stop_c) begin
      nxt_st     = ST_IDLE; // see R19
      nxt_sda_oe = 1'b0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          nxt_sda_oe = 1'b0; // see R6
        end
        ST_ADDR, ST_RXB: begin
          if (scl_rise) begin
            nxt_sh  = {sh_ff[6:0], sda_f_ff}; // see R9
            nxt_bit = bit_ff + 4'h1;
          end else if (scl_fall && bit_ff == 4'h8) begin
            if (st_ff == ST_ADDR) begin
              if (sh_ff[7:1] == my_addr) begin
                nxt_sda_oe = 1'b1; // see R13
                nxt_rw     = sh_ff[0]; // see R12
                nxt_ph     = PH_AHI;
                nxt_st     = ST_ACK_RX;
              end else begin
                nxt_st = ST_IDLE; // see R6
              end
            end else begin
              nxt_sda_oe = 1'b1; // see R10
              nxt_st     = ST_ACK_RX;
              case (ph_ff)
                PH_AHI: begin
                  nxt_ptr[15:8] = sh_ff; // see R15
                  nxt_ph        = PH_ALO;
                end
                PH_ALO: begin
                  nxt_ptr[7:0] = sh_ff; // see R20
                  nxt_ph       = PH_DATA;
                end
                default: begin
                  nxt_wr  = 1'b1; // see R15
                  nxt_wd  = sh_ff;
                  nxt_ptr = ptr_ff + 16'h0001; // see R22
                end
              endcase
            end
          end
        end
        ST_ACK_RX: begin
          // Release ack at the fall ending the ninth pulse
          if (scl_fall) begin
            nxt_bit = 4'h0;
            if (rw_ff == DIR_READ) begin
              nxt_st     = ST_TXB; // see R16
              nxt_rd     = 1'b1;
              nxt_sh     = REG_OK ? REG_RDATA : 8'h00; // see R23
              nxt_sda_oe = !(REG_OK ? REG_RDATA[7] : 1'b0); // see R7
              nxt_ptr    = ptr_ff + 16'h0001; // see R22
            end else begin
              nxt_st     = ST_RXB; // see R14
              nxt_sda_oe = 1'b0;
            end
          end
        end
        ST_TXB: begin
          if (scl_fall) begin
            nxt_bit = bit_ff + 4'h1;
            if (bit_ff == 4'h7) begin
              nxt_sda_oe = 1'b0; // Release for master ack
              nxt_st     = ST_ACK_TX;
            end else begin
              nxt_sh     = {sh_ff[6:0], 1'b0};
              nxt_sda_oe = !sh_ff[6]; // see R9
            end
          end
        end
        ST_ACK_TX: begin
          if (scl_rise) begin
            nxt_nack = sda_f_ff; // see R11
          end else if (scl_fall) begin
            nxt_bit = 4'h0;
            if (nack_ff) begin
              nxt_st     = ST_IDLE; // see R17
              nxt_sda_oe = 1'b0;
            end else begin
              nxt_st     = ST_TXB; // see R14
              nxt_rd     = 1'b1;
              nxt_sh     = REG_OK ? REG_RDATA : 8'h00; // see R23
              nxt_sda_oe = !(REG_OK ? REG_RDATA[7] : 1'b0);
              nxt_ptr    = ptr_ff + 16'h0001; // see R22
            end
          end
        end
        default: nxt_st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_ff     <= ST_IDLE;
      ph_ff     <= PH_AHI;
      sh_ff     <= 8'h00;
      bit_ff    <= 4'h0;
      ptr_ff    <= REG_PTR_RST;
      rw_ff     <= DIR_WRITE;
      sda_oe_ff <= 1'b0;
      wr_ff     <= 1'b0;
      wd_ff     <= 8'h00;
      rd_ff     <= 1'b0;
      nack_ff   <= 1'b0;
    end else begin
      st_ff     <= nxt_st;
      ph_ff     <= nxt_ph;
      sh_ff     <= nxt_sh;
      bit_ff    <= nxt_bit;
      ptr_ff    <= nxt_ptr;
      rw_ff     <= nxt_rw;
      sda_oe_ff <= nxt_sda_oe;
      wr_ff     <= nxt_wr;
      wd_ff     <= nxt_wd;
      rd_ff     <= nxt_rd;
      nack_ff   <= nxt_nack;
    end
  end

  // Register side: address is the live pointer, one less during the write strobe; write strobe follows the byte
  assign REG_ADDR      = wr_ff ? ptr_ff - 16'h0001 : ptr_ff;
  assign REG_WR        = wr_ff;
  assign REG_WDATA     = wd_ff;
  assign REG_RD        = rd_ff;
  assign LINK.sda_s_o  = 1'b0; // Open drain: only ever pulls low; clock is never driven, see R3
  assign LINK.sda_s_oe = sda_oe_ff;
endmodule

/* logic/irsp_master.sv */
// Far end: two-wire master issuing register writes and combined reads
`timescale 1ns/1ps
module irsp_master
  import irsp_pkg::*;
#(
  parameter int HALF_CYC = irsp_pkg::SCL_HALF_CYC
) (
  input  wire logic                        CLK,
  input  wire logic                        ARST_N,
  irsp_if.master                           LINK,
  input  wire logic                        CMD_VALID,
  output logic                             CMD_READY,
  input  wire logic                        CMD_READ,
  input  wire logic [6:0]                  CMD_SLAVE,
  input  wire logic [irsp_pkg::ADDR_W-1:0] CMD_ADDR,
  input  wire logic [4:0]                  CMD_LEN,
  input  wire logic [irsp_pkg::BYTE_W-1:0] WR_DATA,
  input  wire logic                        WR_VALID,
  output logic                             WR_READY,
  output logic      [irsp_pkg::BYTE_W-1:0] RD_DATA,
  output logic                             RD_VALID,
  input  wire logic                        RD_READY,
  output logic                             ACK_ERR
);
  import irsp_pkg::*;

  typedef enum {MS_IDLE, MS_START, MS_BIT, MS_STOP} irsp_ms_t;

  ////////////////////////////////////////////////////////////////////////////
  // Read data buffer; full buffer stalls the clock before the next read byte
  logic       fi_valid, fi_ready;
  logic [7:0] fi_data;
  irsp_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_rxq (
    .CLK      (CLK),
    .ARST_N   (ARST_N),
    .IN_DATA  (fi_data),
    .IN_VALID (fi_valid),
    .IN_READY (fi_ready),
    .OUT_DATA (RD_DATA),
    .OUT_VALID(RD_VALID),
    .OUT_READY(RD_READY)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Byte sequencer; byte index 0 address, then 1-2 pointer and any data when write-addressed, data from 1 when read-addressed
  irsp_ms_t    st_ff, nxt_st;
  logic [15:0] tm_ff, nxt_tm;
  logic [1:0]  q_ff, nxt_q;      // Quarter of bit period
  logic [3:0]  bit_ff, nxt_bit;
  logic [7:0]  sh_ff, nxt_sh;
  logic [5:0]  idx_ff, nxt_idx;
  logic        rd_ff, nxt_rd;    // Current frame is read-addressed
  logic        cmdrd_ff, nxt_cmdrd;
  logic [6:0]  sla_ff, nxt_sla;
  logic [15:0] adr_ff, nxt_adr;
  logic [4:0]  len_ff, nxt_len;
  logic        scl_ff, nxt_scl, sda_ff, nxt_sda;
  logic        err_ff, nxt_err;
  logic [1:0]  sdi_ff;           // Synchroniser for the returned data line
  logic        tick;

  assign tick      = (tm_ff == 16'((HALF_CYC + 1) / 2 - 1)); // Round up: bit rate stays within the bus limit
  assign CMD_READY = (st_ff == MS_IDLE);

  always_comb begin
    nxt_st = st_ff; nxt_tm = tick ? 16'h0 : tm_ff + 16'h1; nxt_q = q_ff; nxt_bit = bit_ff;
    nxt_sh = sh_ff; nxt_idx = idx_ff; nxt_rd = rd_ff; nxt_cmdrd = cmdrd_ff; nxt_sla = sla_ff;
    nxt_adr = adr_ff; nxt_len = len_ff; nxt_scl = scl_ff; nxt_sda = sda_ff; nxt_err = err_ff;
    fi_valid = 1'b0; fi_data = sh_ff; WR_READY = 1'b0;
    case (st_ff)
      MS_IDLE: begin
        nxt_scl = 1'b1; nxt_sda = 1'b1; nxt_q = 2'h0;
        if (CMD_VALID) begin
          nxt_sla = CMD_SLAVE; nxt_adr = CMD_ADDR; nxt_len = CMD_LEN; nxt_cmdrd = CMD_READ;
          nxt_rd = 1'b0; nxt_err = 1'b0; nxt_st = MS_START; nxt_tm = 16'h0;
        end
      end
      MS_START: if (tick) begin
        // Clock up first, so a repeated start also drops data with clock high
        nxt_q = q_ff + 2'h1;
        if (q_ff == 2'h0) nxt_scl = 1'b1;
        if (q_ff == 2'h1) nxt_sda = 1'b0;
        if (q_ff == 2'h2) begin
          nxt_scl = 1'b0; nxt_idx = 6'h0; nxt_bit = 4'h0; nxt_q = 2'h0;
          nxt_sh = {sla_ff, rd_ff}; nxt_st = MS_BIT;
        end
      end
      MS_BIT: if (tick) begin
        nxt_q = q_ff + 2'h1;
        case (q_ff)
          2'h0: nxt_sda = (bit_ff == 4'h8) ? !(rd_ff && idx_ff != 6'h0 && len_ff != 5'h0) :
                          (rd_ff && idx_ff != 6'h0) ? 1'b1 : sh_ff[7];
          2'h1: nxt_scl = 1'b1;
          2'h2: if (!rd_ff || idx_ff == 6'h0 || bit_ff == 4'h8) begin
                  if (bit_ff == 4'h8 && (!rd_ff || idx_ff == 6'h0)) nxt_err = err_ff | sdi_ff[1];
                end else nxt_sh = {sh_ff[6:0], sdi_ff[1]};
          default: begin
            nxt_scl = 1'b0; nxt_q = 2'h0;
            if (bit_ff != 4'h8) begin
              nxt_bit = bit_ff + 4'h1;
              if (!rd_ff || idx_ff == 6'h0) nxt_sh = {sh_ff[6:0], 1'b0};
              if (rd_ff && idx_ff != 6'h0 && bit_ff == 4'h7) begin
                fi_valid = 1'b1; nxt_len = len_ff - 5'h1;
              end
            end else if (rd_ff && idx_ff != 6'h0 && len_ff == 5'h0) begin
              nxt_st = MS_STOP; nxt_sda = 1'b0;
            end else if (!rd_ff && idx_ff == 6'h2 && cmdrd_ff) begin
              nxt_rd = 1'b1; nxt_st = MS_START; nxt_sda = 1'b1; // Repeated start
            end else if (!rd_ff && idx_ff >= 6'h2 && (len_ff == 5'h0 || !WR_VALID)) begin
              nxt_st = MS_STOP; nxt_sda = 1'b0; // Stop right after the last acked byte, see R18
            end else if (rd_ff && !fi_ready) begin
              nxt_q = 2'h3; nxt_scl = 1'b0; // Hold clock low until buffer has room
            end else begin
              nxt_bit = 4'h0; nxt_idx = idx_ff + 6'h1;
              if (!rd_ff && idx_ff == 6'h0) nxt_sh = adr_ff[15:8];
              else if (!rd_ff && idx_ff == 6'h1) nxt_sh = adr_ff[7:0];
              else if (!rd_ff) begin
                nxt_sh = WR_DATA; WR_READY = 1'b1; nxt_len = len_ff - 5'h1;
              end
            end
          end
        endcase
      end
      MS_STOP: if (tick) begin
        nxt_q = q_ff + 2'h1;
        if (q_ff == 2'h1) nxt_scl = 1'b1;
        if (q_ff == 2'h2) begin
          nxt_sda = 1'b1; nxt_st = MS_IDLE;
        end
      end
      default: nxt_st = MS_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_ff <= MS_IDLE; tm_ff <= 16'h0; q_ff <= 2'h0; bit_ff <= 4'h0; sh_ff <= 8'h00;
      idx_ff <= 6'h0; rd_ff <= 1'b0; cmdrd_ff <= 1'b0; sla_ff <= 7'h00; adr_ff <= 16'h0000;
      len_ff <= 5'h00; scl_ff <= 1'b1; sda_ff <= 1'b1; err_ff <= 1'b0; sdi_ff <= 2'h3;
    end else begin
      st_ff <= nxt_st; tm_ff <= nxt_tm; q_ff <= nxt_q; bit_ff <= nxt_bit; sh_ff <= nxt_sh;
      idx_ff <= nxt_idx; rd_ff <= nxt_rd; cmdrd_ff <= nxt_cmdrd; sla_ff <= nxt_sla; adr_ff <= nxt_adr;
      len_ff <= nxt_len; scl_ff <= nxt_scl; sda_ff <= nxt_sda; err_ff <= nxt_err;
      sdi_ff <= {sdi_ff[0], LINK.sda};
    end
  end

  assign LINK.scl_o    = 1'b0;
  assign LINK.scl_oe   = !scl_ff;
  assign LINK.sda_m_o  = 1'b0;
  assign LINK.sda_m_oe = !sda_ff;
  assign ACK_ERR       = err_ff;
endmodule

/* test/irsp_link_asserts.sv */
// Wire-level checker for the slave end of the two-wire register link
`timescale 1ns/1ps
module irsp_link_asserts #(
  parameter logic [6:0] SLV_ADDR = 7'h4d
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  logic       scl_q, sda_q, match_ff, rd_ff, nack_ff;
  logic [3:0] bit_ff, byte_ff;
  logic [6:0] shf_ff;
  wire        rise  = scl && !scl_q;
  wire        start = scl && scl_q && sda_q && !sda;
  wire        pull  = sda_s_oe && !sda_s_o;
  wire        ack9  = rise && (bit_ff == 4'h8);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  ////////////////////////////////////////////////////////////////
  // Frame tracker on the raw wires; a start restarts it, so a torn byte is dropped here too
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      {scl_q, sda_q} <= 2'b11;
      {match_ff, rd_ff, nack_ff, bit_ff, byte_ff} <= 11'h000;
      shf_ff <= 7'h00;
    end else begin
      {scl_q, sda_q} <= {scl, sda};
      if (start) begin
        {match_ff, rd_ff, nack_ff, bit_ff, byte_ff} <= 11'h000;
      end else if (rise) begin
        shf_ff <= {shf_ff[5:0], sda};
        bit_ff <= (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
        if (bit_ff == 4'h8 && byte_ff != 4'hf) begin
          byte_ff <= byte_ff + 4'h1;
        end
        if (bit_ff == 4'h7 && byte_ff == 4'h0) begin
          {match_ff, rd_ff} <= {shf_ff == SLV_ADDR, sda};
        end
        if (ack9 && byte_ff != 4'h0 && rd_ff && match_ff && sda) begin
          nack_ff <= 1'b1;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // Ack slot seen from its rising edge: held low, or left free, for the start of the pulse
  sequence s_pull_hold;
    (pull && scl) [*3];
  endsequence
  sequence s_free_hold;
    (!pull && scl) [*3];
  endsequence
  AST_SLV_STABLE_HIGH: assert property (scl && scl_q |-> $stable(pull))
    else $error("slave data moved while clock high");
  AST_ADDR_ACK: assert property (ack9 && byte_ff == 4'h0 && match_ff |-> s_pull_hold)
    else $error("matched address not acknowledged");
  AST_NO_MATCH: assert property (ack9 && byte_ff == 4'h0 && !match_ff |-> s_free_hold)
    else $error("foreign address acknowledged");
  AST_WR_ACK: assert property (ack9 && byte_ff != 4'h0 && match_ff && !rd_ff |-> s_pull_hold)
    else $error("written byte not acknowledged");
  AST_RD_SLOT_FREE: assert property (ack9 && byte_ff != 4'h0 && match_ff && rd_ff |-> s_free_hold)
    else $error("slave held data in master ack slot");
  AST_NACK_IDLE: assert property (nack_ff |-> !pull)
    else $error("slave drove data after read nack");
  AST_ADDR_QUIET: assert property (byte_ff == 4'h0 && bit_ff inside {[1:7]} |-> !pull)
    else $error("slave drove during address byte");
  AST_WR_BITS_QUIET: assert property (match_ff && !rd_ff && byte_ff != 4'h0 && bit_ff inside {[1:7]} |-> !pull)
    else $error("slave drove during written bits");
  AST_CLK_MASTER_ONLY: assert property (!(scl_oe && scl_o) && !(sda_m_oe && sda_m_o) && (scl || scl_oe))
    else $error("line driven high or clock low without master");
endmodule

/* test/tb_top.sv */
// Self-checking bench: master end and slave end face each other over the link
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  import irsp_pkg::*;
  localparam logic [2:0] STRAP_V = 3'h5;
  localparam logic [6:0] SLV     = {ADDR_FIXED, STRAP_V};
  logic        CLK = 1'b0;
  logic        ARST_N = 1'b0;
  logic [2:0]  STRAP = STRAP_V;
  logic        CMD_VALID = 1'b0, CMD_READ = 1'b0, WR_VALID = 1'b0, RD_READY = 1'b0;
  logic [6:0]  CMD_SLAVE = 7'h00;
  logic [15:0] CMD_ADDR = 16'h0000;
  logic [4:0]  CMD_LEN = 5'h00;
  logic [7:0]  WR_DATA = 8'h00;
  logic [15:0] REG_ADDR;
  logic [7:0]  REG_WDATA, REG_RDATA, RD_DATA;
  logic        REG_WR, REG_RD, REG_OK, CMD_READY, WR_READY, RD_VALID, ACK_ERR;
  logic [7:0]  mem [256];
  logic [7:0]  ref_mem [256];
  logic [7:0]  wr_q[$], exp_rd[$];
  logic [23:0] exp_wr[$];
  int          error_cnt = 0, compares = 0, stall = 0;
  irsp_if irsp_if_i ();
  irsp_slave irsp_slave_i (.CLK(CLK), .ARST_N(ARST_N), .LINK(irsp_if_i.slave), .STRAP(STRAP),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .REG_OK(REG_OK));
  irsp_master irsp_master_i (.CLK(CLK), .ARST_N(ARST_N), .LINK(irsp_if_i.master),
    .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_READ(CMD_READ), .CMD_SLAVE(CMD_SLAVE),
    .CMD_ADDR(CMD_ADDR), .CMD_LEN(CMD_LEN), .WR_DATA(WR_DATA), .WR_VALID(WR_VALID), .WR_READY(WR_READY),
    .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .RD_READY(RD_READY), .ACK_ERR(ACK_ERR));
  irsp_link_asserts #(.SLV_ADDR(SLV)) irsp_link_asserts_i (.CLK(CLK), .ARST_N(ARST_N),
    .scl_o(irsp_if_i.scl_o), .scl_oe(irsp_if_i.scl_oe), .sda_m_o(irsp_if_i.sda_m_o),
    .sda_m_oe(irsp_if_i.sda_m_oe), .sda_s_o(irsp_if_i.sda_s_o), .sda_s_oe(irsp_if_i.sda_s_oe),
    .scl(irsp_if_i.scl), .sda(irsp_if_i.sda));
  ////////////////////////////////////////////////////////////////
  // Register file: only page zero exists; other pages flag denial and offer junk that must not leak
  assign REG_OK    = (REG_ADDR[15:8] == 8'h00);
  assign REG_RDATA = REG_OK ? mem[REG_ADDR[7:0]] : 8'ha5;
  always @(posedge CLK) begin
    if (REG_WR === 1'b1 && REG_OK) begin
      mem[REG_ADDR[7:0]] <= REG_WDATA;
    end
  end
  // Monitor: every write strobe and every delivered read byte retires the oldest note
  always @(posedge CLK) begin
    if (REG_WR === 1'b1) `CHK({REG_ADDR, REG_WDATA}, (exp_wr.size() > 0) ? exp_wr.pop_front() : 24'hx)
    if (RD_VALID === 1'b1 && RD_READY) `CHK(RD_DATA, (exp_rd.size() > 0) ? exp_rd.pop_front() : 8'hx)
  end
  // Write data source and read sink; the sink can be held off, for 9000 clocks in the main sequence, which ends before the buffer fills
  always @(posedge CLK) begin
    if (WR_VALID && WR_READY === 1'b1) begin
      wr_q.delete(0);
    end
    WR_VALID <= (wr_q.size() > 0);
    WR_DATA  <= (wr_q.size() > 0) ? wr_q[0] : 8'h00;
    stall    <= (stall > 0) ? stall - 1 : 0;
    RD_READY <= (stall == 0) && ($urandom_range(3) != 0);
  end
  always #25 CLK = ~CLK;
  ////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Bounded wait for an idle master; running out counts as a fault and ends the run
  task automatic wait_ready(input int lim);
    for (int k = 0; k <= lim; k++) begin
      @(negedge CLK);
      if (CMD_READY === 1'b1) return;
    end
    error_cnt++;
    close_out();
  endtask
  // One command: hand over, wait for the frame to end and all notes to retire, then check the ack flag
  task automatic run(input logic r, input logic [6:0] sa, input logic [15:0] a, input int n, input logic err);
    wait_ready(100);
    @(posedge CLK);
    {CMD_READ, CMD_SLAVE, CMD_ADDR, CMD_LEN} <= {r, sa, a, n[4:0]};
    CMD_VALID <= 1'b1;
    wait_ready(100);
    @(posedge CLK);
    CMD_VALID <= 1'b0;
    @(negedge CLK);
    wait_ready(40000);
    for (int k = 0; exp_rd.size() + exp_wr.size() > 0; k++) begin
      if (k > 4000) wait_ready(-1);
      @(negedge CLK);
    end
    `CHK(ACK_ERR, err)
  endtask
  // Note what a write or a combined read of n bytes from a must produce, then run it
  task automatic xfer(input logic r, input logic [15:0] a, input int n);
    logic [15:0] p;
    logic [7:0]  d;
    for (int i = 0; i < n; i++) begin
      p = a + 16'(i);
      d = 8'($urandom());
      if (r) begin
        exp_rd.push_back((p[15:8] == 8'h00) ? ref_mem[p[7:0]] : 8'h00);
      end else begin
        wr_q.push_back(d);
        exp_wr.push_back({p, d});
        if (p[15:8] == 8'h00) ref_mem[p[7:0]] = d;
      end
    end
    run(r, SLV, a, n, 1'b0);
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'h3c6e));
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($urandom());
      ref_mem[i] = mem[i];
    end
    repeat (5) @(posedge CLK);
    ARST_N <= 1'b1;
    xfer(1'b0, 16'h0010, 4);
    xfer(1'b1, 16'h0010, 4);
    xfer(1'b0, 16'h0030, 0);
    xfer(1'b1, 16'h0030, 1);
    xfer(1'b0, 16'h00fe, 3);
    xfer(1'b1, 16'h00fd, 4);
    run(1'b0, SLV ^ 7'h01, 16'h0000, 0, 1'b1);
    stall = 9000;
    xfer(1'b1, 16'h0040, 20);
    repeat (4) xfer(1'($urandom()), 16'h00f8 + 16'($urandom_range(15)), $urandom_range(6, 1));
    close_out();
  end
endmodule
